// [rtl/rpsc_power_ctl.sv]
/*
 * Power-state sequencer and configuration registers of a four-lane retimer.
 * Assumes a serial slave front end on clk delivering single-cycle writes and
 * a combinational read address; pins arrive asynchronously.
 */
`timescale 1ns/1ps
module rpsc_power_ctl
    import rpsc_pkg::*;
(
    input wire logic clk, // 10 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic chipOn, // chip-on pin, async
    input wire logic sink_hotplug_in, // sink hot-plug, async
    input wire logic clkValid, // valid input clock detect, async
    input wire logic signal_detect_gate, // signal detector result
    input wire logic highRate, // rate detector: above redriver threshold
    input wire rpsc_wr_s wrReq, // register write
    input wire logic [7:0] rdAddr, // register read address
    output logic [7:0] rdData, // register read data
    output logic source_hotplug_out, // mirrored hot-plug
    output logic txOutEn, // data and clock outputs driven
    output logic rxTermOn, // input termination connected
    output logic cdrEn, // clock-data recovery on
    output logic retimeMode, // 1 retimer, 0 redriver
    output logic ddcEn, // DDC pass-through on
    output logic arcEn, // return channel on
    output logic funcEn, // function blocks powered
    output rpsc_cfg_s cfg // analog settings
);
    // ------------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------------
    logic [2:0] pinSync;
    logic chipOnS;
    logic hpdS;
    logic clkOkS;

    rpsc_sync #(.WIDTH(3)) u_sync
    (
        .clk(clk),
        .arst_n(arst_n),
        .asyncIn({chipOn, sink_hotplug_in, clkValid}),
        .syncOut(pinSync)
    );
    assign {chipOnS, hpdS, clkOkS} = pinSync;

    // edge history, read only from synchronised levels
    logic chipOnD_ff;
    logic hpdD_ff;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chipOnD_ff <= 1'b0;
            hpdD_ff <= 1'b0;
        end
        else
        begin
            chipOnD_ff <= chipOnS;
            hpdD_ff <= hpdS;
        end
    end
    logic chipOnRise;
    logic hpdFall;
    assign chipOnRise = chipOnS && !chipOnD_ff;
    assign hpdFall = hpdD_ff && !hpdS;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0] pwrdn_ff;
    logic [7:0] term_ff;
    logic [7:0] swing_ff;
    logic [7:0] ratio_ff;
    rpsc_state_e state_ff;
    rpsc_state_e nxt_state;
    logic enterPd;
    logic wr09;

    function automatic logic hitWr(input rpsc_wr_s w, input logic [7:0] ofs);
        hitWr = w.wrEn && (w.addr == ofs);
    endfunction : hitWr

    assign wr09 = hitWr(wrReq, `RPSC_OFS_PWRDN);
    // any transition into power-down, including a chip-on restart
    assign enterPd = (nxt_state == RPSC_PWRDN && state_ff != RPSC_PWRDN) || chipOnRise;

    // configuration store; clears on power-down entry and chip-on rise,
    // a write landing in the same cycle as a clear wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pwrdn_ff <= `RPSC_RST_PWRDN;
            term_ff <= `RPSC_RST_TERM;
            swing_ff <= `RPSC_RST_SWING;
        end
        else
        begin
            // power-down bit survives its own entry, else the device would bounce out
            if (wr09)
                pwrdn_ff <= wrReq.data;
            else if (chipOnRise || (enterPd && !pwrdn_ff[`RPSC_PWRDN_BIT]))
                pwrdn_ff <= `RPSC_RST_PWRDN;
            if (hitWr(wrReq, `RPSC_OFS_TERM))
                term_ff <= wrReq.data;
            else if (enterPd)
                term_ff <= `RPSC_RST_TERM;
            if (hitWr(wrReq, `RPSC_OFS_SWING))
                swing_ff <= wrReq.data;
            else if (enterPd)
                swing_ff <= `RPSC_RST_SWING;
        end
    end

    // clock-ratio bit: only a write sets it, so the PLL stays low-rate otherwise
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ratio_ff <= `RPSC_RST_RATIO;
        else if (hitWr(wrReq, `RPSC_OFS_RATIO))
            ratio_ff <= wrReq.data; // a write wins over a clear
        else if (enterPd || hpdFall)
            ratio_ff <= `RPSC_RST_RATIO;
    end

    // ------------------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------------------
    always_comb
    begin
        case (state_ff)
            RPSC_PWRDN, RPSC_STANDBY, RPSC_NORMAL:
            begin
                if (!chipOnS || !hpdS || pwrdn_ff[`RPSC_PWRDN_BIT])
                    nxt_state = RPSC_PWRDN;
                else if (!clkOkS)
                    nxt_state = RPSC_STANDBY;
                else
                    nxt_state = RPSC_NORMAL;
            end
            default:
                nxt_state = RPSC_PWRDN;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_ff <= RPSC_PWRDN;
        else
            state_ff <= nxt_state;
    end

    // ------------------------------------------------------------------------
    // outputs, all registered; the enables from next state
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            source_hotplug_out <= 1'b0;
            txOutEn <= 1'b0;
            rxTermOn <= 1'b1;
            cdrEn <= 1'b0;
            retimeMode <= 1'b0;
            ddcEn <= 1'b0;
            arcEn <= 1'b0;
            funcEn <= 1'b0;
        end
        else
        begin
            source_hotplug_out <= hpdS;
            // outputs gated by detector only in normal operation
            txOutEn <= (nxt_state == RPSC_NORMAL) && signal_detect_gate;
            cdrEn <= (nxt_state == RPSC_NORMAL) && signal_detect_gate && highRate;
            retimeMode <= highRate;
            rxTermOn <= 1'b1;
            ddcEn <= (nxt_state != RPSC_PWRDN);
            arcEn <= (nxt_state != RPSC_PWRDN);
            funcEn <= chipOnS && (nxt_state != RPSC_PWRDN);
        end
    end

    // analog settings mirror the store
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cfg <= '0;
        else
        begin
            cfg.swing <= swing_ff[`RPSC_SWING_HI:`RPSC_SWING_LO];
            cfg.emphasis <= swing_ff[`RPSC_EMPH_HI:`RPSC_EMPH_LO];
            cfg.txTerm <= term_ff[`RPSC_TERM_HI:`RPSC_TERM_LO];
            cfg.ratioHigh <= ratio_ff[`RPSC_RATIO_BIT];
        end
    end

    // read mux, registered; unmapped offsets return zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdData <= 8'h00;
        else
        begin
            case (rdAddr)
                `RPSC_OFS_PWRDN: rdData <= pwrdn_ff;
                `RPSC_OFS_TERM: rdData <= term_ff;
                `RPSC_OFS_SWING: rdData <= swing_ff;
                `RPSC_OFS_RATIO: rdData <= ratio_ff;
                `RPSC_OFS_STATUS: rdData <= {state_ff == RPSC_PWRDN, state_ff == RPSC_STANDBY, 6'h00};
                default: rdData <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chipoff_pd_a: assert property (!chipOnS |=> state_ff == RPSC_PWRDN && !funcEn)
        else $error("chip-on low did not power down");
    rise_clr_a: assert property (chipOnRise && !hitWr(wrReq, `RPSC_OFS_SWING) |=> swing_ff == `RPSC_RST_SWING)
        else $error("chip-on rise did not clear configuration");
    swpd_write_a: assert property (wr09 && wrReq.data[`RPSC_PWRDN_BIT] |-> ##2 state_ff == RPSC_PWRDN)
        else $error("power-down write ignored");
    hpd_low_pd_a: assert property (chipOnS && !hpdS |=> state_ff == RPSC_PWRDN)
        else $error("hot-plug low not power-down");
    standby_a: assert property (chipOnS && hpdS && !clkOkS && !pwrdn_ff[3] |=> state_ff == RPSC_STANDBY)
        else $error("missing standby");
    hpd_mirror_a: assert property (source_hotplug_out == $past(hpdS))
        else $error("hot-plug not mirrored");
    ratio_clr_a: assert property (hpdFall && !hitWr(wrReq, `RPSC_OFS_RATIO) |=> ratio_ff == 8'h00)
        else $error("ratio bit not cleared");
    tx_hiz_a: assert property (state_ff != RPSC_NORMAL |-> !txOutEn || $past(nxt_state) == RPSC_NORMAL)
        else $error("outputs driven outside normal");
    ddc_en_a: assert property (ddcEn == ($past(nxt_state) != RPSC_PWRDN) && arcEn == ddcEn)
        else $error("DDC enable mismatch");
    pd_clear_a: assert property (state_ff != RPSC_PWRDN && nxt_state == RPSC_PWRDN && !hitWr(wrReq, `RPSC_OFS_TERM)
        |=> term_ff == `RPSC_RST_TERM)
        else $error("registers not cleared on power-down");

    normal_c: cover property (state_ff == RPSC_STANDBY ##1 state_ff == RPSC_NORMAL);
    swpd_c: cover property (state_ff == RPSC_NORMAL ##1 wr09 ##1 state_ff == RPSC_PWRDN);
    ratio_c: cover property (cfg.ratioHigh ##1 hpdFall);
endmodule : rpsc_power_ctl

// [rtl/rpsc_sync.sv]
/*
 * Two-flop synchroniser for a bundle of asynchronous pin levels.
 * Assumes the inputs are levels held far longer than one clock period.
 */
`timescale 1ns/1ps
module rpsc_sync
    import rpsc_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    input wire logic clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic [WIDTH-1:0] asyncIn, // raw pin levels
    output logic [WIDTH-1:0] syncOut // synchronised levels
);
    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_ff <= '0;
            syncOut <= '0;
        end
        else
        begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule : rpsc_sync

// [shared/rpsc_defines.svh]
/*
 * Register offsets, field positions, reset values and encodings of the
 * retimer power-state control block.
 * Assumes inclusion by bare name from the package and the rtl files.
 */
`ifndef RPSC_DEFINES_SVH
`define RPSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define RPSC_OFS_PWRDN 8'h09
`define RPSC_OFS_TERM 8'h0B
`define RPSC_OFS_SWING 8'h0C
`define RPSC_OFS_STATUS 8'h20
`define RPSC_OFS_RATIO 8'h21

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define RPSC_PWRDN_BIT 3
`define RPSC_TERM_HI 4
`define RPSC_TERM_LO 3
`define RPSC_SWING_HI 7
`define RPSC_SWING_LO 2
`define RPSC_EMPH_HI 1
`define RPSC_EMPH_LO 0
`define RPSC_STAT_PD_BIT 7
`define RPSC_STAT_SB_BIT 6
`define RPSC_RATIO_BIT 1
`define RPSC_RST_PWRDN 8'h00
`define RPSC_RST_TERM 8'h00
`define RPSC_RST_SWING 8'h00
`define RPSC_RST_RATIO 8'h00

`endif

// [shared/rpsc_pkg.sv]
/*
 * Types of the retimer power-state control block.
 * Assumes rpsc_defines.svh is reachable on the include path.
 */
package rpsc_pkg;
    `include "rpsc_defines.svh"

    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {RPSC_PWRDN, RPSC_STANDBY, RPSC_NORMAL} rpsc_state_e;

    // register write request from the serial slave front end
    typedef struct packed {
        logic wrEn;
        logic [7:0] addr;
        logic [7:0] data;
    } rpsc_wr_s;

    // settings handed to the analog output stage
    typedef struct packed {
        logic [5:0] swing;
        logic [1:0] emphasis;
        logic [1:0] txTerm;
        logic ratioHigh;
    } rpsc_cfg_s;
endpackage : rpsc_pkg

// [tb/rpsc_link_source.sv]
/*
 * Behavioural model of the link source facing the retimer inputs.
 * Assumes the bench picks the link mode; levels change at falling edges.
 */
`timescale 1ns/1ps
module rpsc_link_source
    import rpsc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic [1:0] linkMode, // 0 idle, 1 low rate, 2 high rate
    output logic clkValid, // clock lane carries a valid clock
    output logic sigDetect, // detector sees a valid signal
    output logic highRate // rate above redriver threshold
);
    // ------------------------------------------------------------------------
    // link levels
    // ------------------------------------------------------------------------
    // an idle source sends no clock, so no detect and no rate either
    initial
    begin
        clkValid = 1'b0;
        sigDetect = 1'b0;
        highRate = 1'b0;
    end
    always @(negedge clk)
    begin
        clkValid <= (linkMode != 2'h0);
        sigDetect <= (linkMode != 2'h0);
        highRate <= (linkMode == 2'h2);
    end
endmodule : rpsc_link_source

// [tb/tb_retimer_power_state_control.sv]
/*
 * Self-checking bench of the retimer power-state control block.
 * Assumes the source model drives the link levels and the bench drives pins
 * and register accesses at falling edges.
 */
`timescale 1ns/1ps
module tb_retimer_power_state_control;
    import rpsc_pkg::*;
    logic clk, arst_n, chipOn, hotplug, clkValid, sigDetect, highRate;
    logic srcHp, txOutEn, rxTermOn, cdrEn, retimeMode, ddcEn, arcEn, funcEn;
    logic [1:0] linkMode;
    logic [7:0] rdAddr, rdData, rd;
    rpsc_wr_s wrReq;
    rpsc_cfg_s cfg;
    int n_errors = 0;
    int tests_run = 0;

    // ------------------------------------------------------------------------
    // clock, partner and design
    // ------------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    rpsc_link_source src (.clk(clk), .linkMode(linkMode), .clkValid(clkValid),
        .sigDetect(sigDetect), .highRate(highRate));
    rpsc_power_ctl dut (.clk(clk), .arst_n(arst_n), .chipOn(chipOn), .sink_hotplug_in(hotplug),
        .clkValid(clkValid), .signal_detect_gate(sigDetect), .highRate(highRate), .wrReq(wrReq),
        .rdAddr(rdAddr), .rdData(rdData), .source_hotplug_out(srcHp), .txOutEn(txOutEn),
        .rxTermOn(rxTermOn), .cdrEn(cdrEn), .retimeMode(retimeMode), .ddcEn(ddcEn),
        .arcEn(arcEn), .funcEn(funcEn), .cfg(cfg));

    // ------------------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one-cycle strobe, dropped a full cycle later so writes never overlap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) wrReq = '{1'b1, a, d};
        @(negedge clk) wrReq.wrEn = 1'b0;
    endtask : wr

    // read data is registered, so it is taken one cycle after the address
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk) rdAddr = a;
        @(negedge clk) rd = rdData;
        check($sformatf("reg %h", a), rd, exp);
    endtask : rdChk

    // pins pass a two-flop synchroniser, so allow it to settle
    task automatic pins(input logic on, input logic hp, input logic [1:0] mode);
        @(negedge clk);
        chipOn = on;
        hotplug = hp;
        linkMode = mode;
        repeat (6) @(negedge clk);
    endtask : pins

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        arst_n = 1'b0;
        chipOn = 1'b0;
        hotplug = 1'b0;
        linkMode = 2'h0;
        rdAddr = 8'h00;
        wrReq = '0;
        repeat (6) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        repeat (2) @(negedge clk);
        rdChk(8'h09, 8'h00);
        rdChk(8'h0B, 8'h00);
        rdChk(8'h0C, 8'h00);
        rdChk(8'h20, 8'h80);
        check("funcEn", funcEn, 1'b0);
        check("rxTermOn", rxTermOn, 1'b1);
        $display("test reset done");

        pins(1'b1, 1'b0, 2'h0);
        rdChk(8'h20, 8'h80);
        check("srcHp", srcHp, 1'b0);
        check("ddcEn", ddcEn, 1'b0);
        check("arcEn", arcEn, 1'b0);
        pins(1'b1, 1'b1, 2'h0);
        rdChk(8'h20, 8'h40);
        check("srcHp", srcHp, 1'b1);
        check("txOutEn", txOutEn, 1'b0);
        check("rxTermOn", rxTermOn, 1'b1);
        check("ddcEn", ddcEn, 1'b1);
        check("arcEn", arcEn, 1'b1);
        $display("test power states done");

        pins(1'b1, 1'b1, 2'h2);
        rdChk(8'h20, 8'h00);
        check("txOutEn", txOutEn, 1'b1);
        check("retimeMode", retimeMode, 1'b1);
        check("cdrEn", cdrEn, 1'b1);
        pins(1'b1, 1'b1, 2'h1);
        check("retimeMode", retimeMode, 1'b0);
        check("txOutEn", txOutEn, 1'b1);
        check("cdrEn", cdrEn, 1'b0);
        $display("test normal modes done");

        wr(8'h0C, 8'hA5);
        wr(8'h21, 8'h02);
        wr(8'h30, 8'h77);
        wr(8'h20, 8'hFF);
        rdChk(8'h0C, 8'hA5);
        check("swing", {2'b00, cfg.swing}, 8'h29);
        check("emphasis", {6'h00, cfg.emphasis}, 8'h01);
        check("ratioHigh", {7'h00, cfg.ratioHigh}, 8'h01);
        rdChk(8'h30, 8'h00);
        rdChk(8'h20, 8'h00);
        for (int t = 0; t < 4; t++)
        begin
            wr(8'h0B, 8'(t << 3));
            rdChk(8'h0B, 8'(t << 3));
            check("txTerm", {6'h00, cfg.txTerm}, 8'(t));
        end
        $display("test registers done");

        pins(1'b1, 1'b0, 2'h1);
        check("srcHp", srcHp, 1'b0);
        rdChk(8'h21, 8'h00);
        pins(1'b1, 1'b1, 2'h2);
        wr(8'h21, 8'h02);
        wr(8'h0C, 8'hFC);
        wr(8'h09, 8'h08);
        repeat (2) @(negedge clk);
        rdChk(8'h20, 8'h80);
        check("txOutEn", txOutEn, 1'b0);
        rdChk(8'h0C, 8'h00);
        rdChk(8'h21, 8'h00);
        check("ratioHigh", {7'h00, cfg.ratioHigh}, 8'h00);
        rdChk(8'h09, 8'h08);
        wr(8'h09, 8'h00);
        repeat (2) @(negedge clk);
        rdChk(8'h20, 8'h00);
        $display("test clears done");

        pins(1'b0, 1'b1, 2'h2);
        check("funcEn", funcEn, 1'b0);
        check("srcHp", srcHp, 1'b1);
        wr(8'h0B, 8'h18);
        pins(1'b1, 1'b1, 2'h2);
        rdChk(8'h0B, 8'h00);
        check("funcEn", funcEn, 1'b1);
        $display("test chip-on done");
        stop_test();
    end
endmodule : tb_retimer_power_state_control
